// *** rtl/hbc_top.sv ***
// H-bridge output control, fault supervision and serial register access.
`timescale 1ns/1ps

module hbc_top (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso,
  input  wire hbc_pkg::hbc_pins_type pins,
  input  wire hbc_pkg::hbc_sense_type sense,
  output hbc_pkg::hbc_drive_type     power_output_one,
  output hbc_pkg::hbc_drive_type     power_output_two,
  output logic                       fault_status_output_n,
  output logic                       current_limit_active,
  output logic [1:0]                 current_limit_select,
  output logic [2:0]                 slew_rate_select
);

  function automatic logic [hbc_pkg::FILT_W-1:0] filt_next(input logic [hbc_pkg::FILT_W-1:0] cnt,
                                                           input logic active,
                                                           input logic [hbc_pkg::FILT_W-1:0] limit);
    if (!active) begin
      filt_next = '0;
    end else if (cnt == limit) begin
      filt_next = cnt;
    end else begin
      filt_next = cnt + 1'b1;
    end
  endfunction

  function automatic hbc_pkg::hbc_drive_type drive_of(input logic live, input logic level);
    drive_of.high_side = live & level;
    drive_of.low_side  = live & ~level;
  endfunction

  // Link side, clocked by the serial clock.
  logic [3:0]                   bit_cnt_q;
  logic [hbc_pkg::FRAME_W-2:0]  rx_shift_q;
  logic [hbc_pkg::FRAME_W-1:0]  rx_word_q;
  logic                         rx_tgl_q;
  logic [hbc_pkg::FRAME_W-1:0]  tx_word_q;
  logic                         miso_q;

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge spi_sclk) begin
    rx_shift_q <= {rx_shift_q[hbc_pkg::FRAME_W-3:0], spi_mosi};
    if (bit_cnt_q == 4'hf) begin
      rx_word_q <= {rx_shift_q, spi_mosi};
    end
  end

  always_ff @(posedge spi_sclk or posedge reset) begin
    if (reset) begin
      rx_tgl_q <= 1'b0;
    end else if (bit_cnt_q == 4'hf) begin
      rx_tgl_q <= ~rx_tgl_q;
    end
  end

  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= tx_word_q[4'hf - bit_cnt_q];
    end
  end

  assign spi_miso = miso_q;

  // Logic side: synchronisers for the frame toggle, pins and comparators.
  logic [2:0]             tgl_sync_q;
  hbc_pkg::hbc_pins_type  pins_s1_q;
  hbc_pkg::hbc_pins_type  pins_s2_q;
  hbc_pkg::hbc_pins_type  pins_s3_q;
  hbc_pkg::hbc_sense_type sense_s1_q;
  hbc_pkg::hbc_sense_type sense_s2_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tgl_sync_q <= 3'h0;
      pins_s1_q  <= '0;
      pins_s2_q  <= '0;
      pins_s3_q  <= '0;
      sense_s1_q <= '0;
      sense_s2_q <= '0;
    end else if (clk_en) begin
      tgl_sync_q <= {tgl_sync_q[1:0], rx_tgl_q};
      pins_s1_q  <= pins;
      pins_s2_q  <= pins_s1_q;
      pins_s3_q  <= pins_s2_q;
      sense_s1_q <= sense;
      sense_s2_q <= sense_s1_q;
    end
  end

  // Register state.
  logic [hbc_pkg::DATA_W-1:0] cfg_q;
  logic [hbc_pkg::DATA_W-1:0] mask_q;
  logic [hbc_pkg::STAT_W-1:0] status_q;
  logic                       uv_lock_q;
  logic                       ov_active_q;
  logic [hbc_pkg::FILT_W-1:0] uv_fall_cnt_q;
  logic [hbc_pkg::FILT_W-1:0] uv_rise_cnt_q;
  logic [hbc_pkg::FILT_W-1:0] ov_cnt_q;
  logic [hbc_pkg::FILT_W-1:0] ot_cnt_q;

  // Frame decode.
  wire                          frame_evt    = tgl_sync_q[2] ^ tgl_sync_q[1];
  wire [hbc_pkg::FRAME_W-1:0]   frame        = rx_word_q;
  wire                          frame_wr     = frame[hbc_pkg::WR_BIT];
  wire [1:0]                    frame_sel    = frame[hbc_pkg::SEL_HI:hbc_pkg::SEL_LO];
  wire [hbc_pkg::DATA_W-1:0]    frame_data   = frame[hbc_pkg::DATA_W-1:0];
  wire                          wr_evt       = frame_evt & frame_wr;
  wire                          wr_ident     = wr_evt & (frame_sel == hbc_pkg::SEL_IDENT);
  wire                          wr_status    = wr_evt & (frame_sel == hbc_pkg::SEL_STATUS);
  wire                          wr_mask      = wr_evt & (frame_sel == hbc_pkg::SEL_MASK);
  wire                          wr_config    = wr_evt & (frame_sel == hbc_pkg::SEL_CONFIG);

  // Synchronised pin levels and pin edges.
  wire in1_s     = pins_s2_q.input_pin_one;
  wire in2_s     = pins_s2_q.input_pin_two;
  wire chip_enable_pin_s    = pins_s2_q.chip_enable_pin;
  wire dis_s     = pins_s2_q.output_disable_pin;
  wire chip_enable_pin_rise = pins_s2_q.chip_enable_pin & ~pins_s3_q.chip_enable_pin;
  wire dis_fall  = ~pins_s2_q.output_disable_pin & pins_s3_q.output_disable_pin;
  wire pin_clr   = chip_enable_pin_rise | dis_fall;

  // Configuration fields.
  wire cfg_al    = cfg_q[hbc_pkg::CF_AL];
  wire cfg_en    = cfg_q[hbc_pkg::CF_EN];
  wire cfg_hmode = cfg_q[hbc_pkg::CF_MODE];
  wire cfg_vsrc  = cfg_q[hbc_pkg::CF_INSRC];
  wire mask_dov  = mask_q[hbc_pkg::MSK_DOV];

  // Filters.
  wire [hbc_pkg::FILT_W-1:0] uv_fall_cnt_d = filt_next(uv_fall_cnt_q, sense_s2_q.uv_below_fall & ~uv_lock_q,
                                                       hbc_pkg::UV_FILT_CYC);
  wire [hbc_pkg::FILT_W-1:0] uv_rise_cnt_d = filt_next(uv_rise_cnt_q, sense_s2_q.uv_above_recover & uv_lock_q,
                                                       hbc_pkg::UV_FILT_CYC);
  wire [hbc_pkg::FILT_W-1:0] ov_cnt_d      = filt_next(ov_cnt_q, sense_s2_q.ov_above,
                                                       hbc_pkg::OV_FILT_CYC);
  wire [hbc_pkg::FILT_W-1:0] ot_cnt_d      = filt_next(ot_cnt_q, sense_s2_q.ot_above,
                                                       hbc_pkg::OT_FILT_CYC);
  wire uv_trip   = (uv_fall_cnt_q == hbc_pkg::UV_FILT_CYC);
  wire uv_recov  = (uv_rise_cnt_q == hbc_pkg::UV_FILT_CYC);
  wire ov_trip   = (ov_cnt_q == hbc_pkg::OV_FILT_CYC);
  wire ot_trip   = (ot_cnt_q == hbc_pkg::OT_FILT_CYC);
  wire uv_lock_d = uv_trip | (uv_lock_q & ~uv_recov);
  wire ov_act_d  = ov_trip | (ov_active_q & ~sense_s2_q.ov_below_hys);

  // Sticky flags: a set in the same cycle as a clear wins, except the thermal warning, which the hysteresis drop clears.
  wire [hbc_pkg::STAT_W-1:0] st_set;
  wire [hbc_pkg::STAT_W-1:0] st_present;
  wire [hbc_pkg::STAT_W-1:0] st_tw_drop;
  assign st_set[hbc_pkg::ST_OT]   = ot_trip;
  assign st_set[hbc_pkg::ST_TW]   = sense_s2_q.tw_above;
  assign st_set[hbc_pkg::ST_OC]   = sense_s2_q.oc_detect;
  assign st_set[hbc_pkg::ST_OL]   = 1'b0;
  assign st_set[hbc_pkg::ST_SCG1] = sense_s2_q.scg_one;
  assign st_set[hbc_pkg::ST_SCG2] = sense_s2_q.scg_two;
  assign st_set[hbc_pkg::ST_SCP1] = sense_s2_q.scp_one;
  assign st_set[hbc_pkg::ST_SCP2] = sense_s2_q.scp_two;
  assign st_set[hbc_pkg::ST_OV]   = ov_trip;
  assign st_set[hbc_pkg::ST_UV]   = uv_trip;
  assign st_set[hbc_pkg::ST_CPU]  = 1'b0;
  assign st_set[hbc_pkg::ST_FRM]  = wr_ident;
  assign st_present[hbc_pkg::ST_OT]   = sense_s2_q.ot_above;
  assign st_present[hbc_pkg::ST_TW]   = 1'b1;
  assign st_present[hbc_pkg::ST_OC]   = sense_s2_q.oc_detect;
  assign st_present[hbc_pkg::ST_OL]   = 1'b0;
  assign st_present[hbc_pkg::ST_SCG1] = sense_s2_q.scg_one;
  assign st_present[hbc_pkg::ST_SCG2] = sense_s2_q.scg_two;
  assign st_present[hbc_pkg::ST_SCP1] = sense_s2_q.scp_one;
  assign st_present[hbc_pkg::ST_SCP2] = sense_s2_q.scp_two;
  assign st_present[hbc_pkg::ST_OV]   = ov_active_q;
  assign st_present[hbc_pkg::ST_UV]   = uv_lock_q;
  assign st_present[hbc_pkg::ST_CPU]  = 1'b0;
  assign st_present[hbc_pkg::ST_FRM]  = 1'b0;
  assign st_tw_drop = sense_s2_q.tw_below_hys ? (12'h001 << hbc_pkg::ST_TW) : 12'h000;

  wire [hbc_pkg::STAT_W-1:0] st_clr   = {hbc_pkg::STAT_W{pin_clr}} |
                                        (wr_status ? frame_data[hbc_pkg::STAT_W-1:0] : 12'h000);
  wire [hbc_pkg::STAT_W-1:0] status_d = (st_set | (status_q & ~(st_clr & ~st_present))) & ~st_tw_drop;

  // Output steering.
  wire sc_one    = status_q[hbc_pkg::ST_SCG1] | status_q[hbc_pkg::ST_SCP1];
  wire sc_two    = status_q[hbc_pkg::ST_SCG2] | status_q[hbc_pkg::ST_SCP2];
  wire force_off = ~cfg_en | ~chip_enable_pin_s | dis_s | uv_lock_q | status_q[hbc_pkg::ST_OT] |
                   (cfg_hmode & (sc_one | sc_two));
  wire level_one = cfg_vsrc ? cfg_q[hbc_pkg::CF_VIRTUAL_INPUT_ONE] : in1_s;
  wire level_two = cfg_vsrc ? cfg_q[hbc_pkg::CF_VIRTUAL_INPUT_TWO] : in2_s;
  wire ov_brake  = cfg_hmode & ov_active_q & ~mask_dov;
  wire h_one     = level_two ? level_one : 1'b1;
  wire h_two     = level_two ? ~level_one : 1'b1;
  wire lvl_power_output_one  = cfg_hmode ? (ov_brake | h_one) : level_one;
  wire lvl_power_output_two  = cfg_hmode ? (ov_brake | h_two) : level_two;
  wire live_one  = ~force_off & (cfg_hmode | ~sc_one);
  wire live_two  = ~force_off & (cfg_hmode | ~sc_two);
  wire [hbc_pkg::STAT_W-1:0] st_view = status_q;
  wire fault_d   = ~(|(st_view & mask_q[hbc_pkg::STAT_W-1:0]) | dis_s);
  wire limit_d   = cfg_al & cfg_hmode & sense_s2_q.oc_detect & ~force_off;

  wire [hbc_pkg::DATA_W-1:0] sel_data = (frame_sel == hbc_pkg::SEL_STATUS) ? {1'b0, st_view} :
                                        (frame_sel == hbc_pkg::SEL_MASK)   ? mask_q :
                                        (frame_sel == hbc_pkg::SEL_CONFIG) ? cfg_q :
                                        hbc_pkg::IDENT_VALUE;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_q  <= hbc_pkg::CONFIG_RESET;
      mask_q <= hbc_pkg::MASK_RESET;
    end else if (clk_en) begin
      if (wr_config) begin
        cfg_q <= frame_data;
      end
      if (wr_mask) begin
        mask_q <= frame_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_word_q <= '0;
    end else if (clk_en && frame_evt) begin
      tx_word_q <= {1'b0, frame_sel, sel_data};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_q      <= '0;
      uv_lock_q     <= 1'b0;
      ov_active_q   <= 1'b0;
      uv_fall_cnt_q <= '0;
      uv_rise_cnt_q <= '0;
      ov_cnt_q      <= '0;
      ot_cnt_q      <= '0;
    end else if (clk_en) begin
      status_q      <= status_d;
      uv_lock_q     <= uv_lock_d;
      ov_active_q   <= ov_act_d;
      uv_fall_cnt_q <= uv_fall_cnt_d;
      uv_rise_cnt_q <= uv_rise_cnt_d;
      ov_cnt_q      <= ov_cnt_d;
      ot_cnt_q      <= ot_cnt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_output_one      <= '0;
      power_output_two      <= '0;
      fault_status_output_n <= 1'b1;
      current_limit_active  <= 1'b0;
      current_limit_select  <= hbc_pkg::CONFIG_RESET[hbc_pkg::CF_IL_HI:hbc_pkg::CF_IL_LO];
      slew_rate_select      <= hbc_pkg::CONFIG_RESET[hbc_pkg::CF_SR_HI:hbc_pkg::CF_SR_LO];
    end else if (clk_en) begin
      power_output_one      <= drive_of(live_one, lvl_power_output_one);
      power_output_two      <= drive_of(live_two, lvl_power_output_two);
      fault_status_output_n <= fault_d;
      current_limit_active  <= limit_d;
      current_limit_select  <= cfg_q[hbc_pkg::CF_IL_HI:hbc_pkg::CF_IL_LO];
      slew_rate_select      <= cfg_q[hbc_pkg::CF_SR_HI:hbc_pkg::CF_SR_LO];
    end
  end

  // Checks on the logic side.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_cfg_off_tristate: assert property (clk_en && !cfg_en |=> power_output_one == '0 && power_output_two == '0)
    else $error("outputs driven while output enable bit is clear");
  a_uv_lock_off: assert property (clk_en && uv_lock_q |=> power_output_one == '0 && power_output_two == '0)
    else $error("outputs driven during undervoltage lockout");
  a_ov_brake_high: assert property (clk_en && ov_brake && !force_off |=>
                                    power_output_one == 2'b10 && power_output_two == 2'b10)
    else $error("overvoltage brake not applied");
  a_ov_flag_sticky: assert property (clk_en && status_q[hbc_pkg::ST_OV] && !pin_clr && !wr_status |=>
                                     status_q[hbc_pkg::ST_OV])
    else $error("overvoltage flag lost without clear");
  a_tw_self_clear: assert property (clk_en && sense_s2_q.tw_below_hys |=> !status_q[hbc_pkg::ST_TW])
    else $error("thermal warning did not clear");
  a_ot_latch_set: assert property (clk_en && ot_trip |=> status_q[hbc_pkg::ST_OT] ##1
                                   power_output_one == '0)
    else $error("overtemperature did not latch outputs off");
  a_ot_latch_hold: assert property (clk_en && status_q[hbc_pkg::ST_OT] && !pin_clr && !wr_status |=>
                                    status_q[hbc_pkg::ST_OT])
    else $error("overtemperature latch released without clear");
  a_virtual_input: assert property (clk_en && !force_off && !cfg_hmode && cfg_vsrc && !sc_one |=>
                                    power_output_one.high_side == $past(cfg_q[hbc_pkg::CF_VIRTUAL_INPUT_ONE]))
    else $error("half bridge one not following virtual input");
  a_filter_restart: assert property (clk_en && !sense_s2_q.uv_below_fall |=> uv_fall_cnt_q == '0)
    else $error("undervoltage filter did not restart");
  a_limit_off: assert property (clk_en && !cfg_al |=> !current_limit_active)
    else $error("current limit active with limit bit clear");
  a_pin_disable_off: assert property (clk_en && (dis_s || !chip_enable_pin_s) |=>
                                      power_output_one == '0 && power_output_two == '0)
    else $error("outputs driven while pins disable them");
  a_half_sc_split: assert property (clk_en && !cfg_hmode && sc_one |=> power_output_one == '0)
    else $error("half bridge one driven after its short circuit");
  a_half_follow: assert property (clk_en && !cfg_hmode && !force_off && !sc_one |=>
                                  power_output_one.high_side == $past(level_one))
    else $error("half bridge one not following its input");
  a_h_map_two: assert property (clk_en && cfg_hmode && !force_off && !ov_brake && level_two |=>
                                power_output_two.high_side == !$past(level_one))
    else $error("bridge output two not opposite to input one");
  a_oc_flag_set: assert property (clk_en && sense_s2_q.oc_detect |=> status_q[hbc_pkg::ST_OC])
    else $error("overcurrent flag not set");
  a_limit_on: assert property (clk_en && cfg_al && cfg_hmode && sense_s2_q.oc_detect && !force_off |=>
                               current_limit_active)
    else $error("current limit not active on overcurrent");
  a_ov_flag_set: assert property (clk_en && ov_trip |=> status_q[hbc_pkg::ST_OV])
    else $error("overvoltage flag not set");
  a_ov_recover: assert property (clk_en && ov_active_q && sense_s2_q.ov_below_hys && !ov_trip |=>
                                 !ov_active_q)
    else $error("overvoltage condition not left");
  a_uv_flag_set: assert property (clk_en && uv_trip |=> status_q[hbc_pkg::ST_UV])
    else $error("undervoltage flag not set");
  a_uv_recover_on: assert property (clk_en && uv_recov && !uv_trip |=> !uv_lock_q)
    else $error("undervoltage lockout not released");
  a_tw_live_set: assert property (clk_en && sense_s2_q.tw_above && !sense_s2_q.tw_below_hys |=>
                                  status_q[hbc_pkg::ST_TW])
    else $error("thermal warning not shown");
  a_ot_drive_off: assert property (clk_en && status_q[hbc_pkg::ST_OT] |=>
                                   power_output_one == '0 && power_output_two == '0)
    else $error("outputs driven while overtemperature latched");
  a_status_clear: assert property (clk_en && wr_status && frame_data[hbc_pkg::ST_OC] && !sense_s2_q.oc_detect |=>
                                   !status_q[hbc_pkg::ST_OC])
    else $error("status write did not clear overcurrent");
  a_pin_clear_ot: assert property (clk_en && pin_clr && !sense_s2_q.ot_above && !ot_trip |=>
                                   !status_q[hbc_pkg::ST_OT])
    else $error("pin clear did not release overtemperature");

  c_ov_brake: cover property (clk_en && ov_brake && !force_off ##1 power_output_one == 2'b10);
  c_ot_latch: cover property (ot_trip ##1 status_q[hbc_pkg::ST_OT]);
  c_uv_recover: cover property (uv_lock_q && uv_recov);
  c_serial_write: cover property (wr_config);
  c_half_short: cover property (!cfg_hmode && sc_one && !force_off);

endmodule

// *** rtl/hbc_pkg.sv ***
// Package with register layout, timing constants and carrier types of the H-bridge control block.
package hbc_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int UV_FILT_NS    = 10000;
  localparam int OV_FILT_NS    = 3000;
  localparam int OT_FILT_NS    = 11000;
  localparam int FILT_W        = 9;
  localparam logic [FILT_W-1:0] UV_FILT_CYC = FILT_W'(UV_FILT_NS / CLK_PERIOD_NS);
  localparam logic [FILT_W-1:0] OV_FILT_CYC = FILT_W'(OV_FILT_NS / CLK_PERIOD_NS);
  localparam logic [FILT_W-1:0] OT_FILT_CYC = FILT_W'(OT_FILT_NS / CLK_PERIOD_NS);

  localparam int FRAME_W = 16;
  localparam int DATA_W  = 13;
  localparam int STAT_W  = 12;
  localparam int WR_BIT  = 15;
  localparam int SEL_HI  = 14;
  localparam int SEL_LO  = 13;

  localparam logic [1:0] SEL_IDENT  = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_MASK   = 2'h2;
  localparam logic [1:0] SEL_CONFIG = 2'h3;

  // Status bit positions; the fault mask uses the same positions.
  localparam int ST_OT   = 0;
  localparam int ST_TW   = 1;
  localparam int ST_OC   = 2;
  localparam int ST_OL   = 3;
  localparam int ST_SCG1 = 4;
  localparam int ST_SCG2 = 5;
  localparam int ST_SCP1 = 6;
  localparam int ST_SCP2 = 7;
  localparam int ST_OV   = 8;
  localparam int ST_UV   = 9;
  localparam int ST_CPU  = 10;
  localparam int ST_FRM  = 11;
  localparam int MSK_DOV = 12;

  // Configuration bit positions.
  localparam int CF_VIRTUAL_INPUT_ONE  = 0;
  localparam int CF_VIRTUAL_INPUT_TWO  = 1;
  localparam int CF_INSRC = 2;
  localparam int CF_MODE  = 3;
  localparam int CF_EN    = 4;
  localparam int CF_SR_LO = 5;
  localparam int CF_SR_HI = 7;
  localparam int CF_IL_LO = 8;
  localparam int CF_IL_HI = 9;
  localparam int CF_AL    = 10;

  localparam logic [DATA_W-1:0] MASK_RESET   = 13'h06f1;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 13'h0d98;
  // Identification value is arbitrary.
  localparam logic [DATA_W-1:0] IDENT_VALUE  = 13'h0010;

  typedef struct packed {
    logic high_side;
    logic low_side;
  } hbc_drive_type;

  typedef struct packed {
    logic input_pin_one;
    logic input_pin_two;
    logic chip_enable_pin;
    logic output_disable_pin;
  } hbc_pins_type;

  typedef struct packed {
    logic uv_below_fall;
    logic uv_above_recover;
    logic ov_above;
    logic ov_below_hys;
    logic tw_above;
    logic tw_below_hys;
    logic ot_above;
    logic oc_detect;
    logic scg_one;
    logic scg_two;
    logic scp_one;
    logic scp_two;
  } hbc_sense_type;

endpackage

// *** bench/hbc_host.sv ***
// Serial host model that frames words to the block and collects the replies.
`timescale 1ns/1ps
module hbc_host (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One word per frame, MSB first, which also carries the serial fault clears.
  task automatic xfer(input logic [15:0] word, output logic [15:0] reply);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = word[i];
      #16;
      spi_sclk = 1'b1;
      reply[i] = spi_miso;
      #16;
      spi_sclk = 1'b0;
    end
    #16;
    spi_cs_n = 1'b1;
    spi_mosi = ~word[0];
    #500;
  endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the H-bridge control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb;
  logic                   sys_clk = 1'b0;
  logic                   reset   = 1'b0;
  logic                   spi_sclk;
  logic                   spi_cs_n;
  logic                   spi_mosi;
  logic                   spi_miso;
  hbc_pkg::hbc_pins_type  pins    = '0;
  hbc_pkg::hbc_sense_type sense   = '0;
  hbc_pkg::hbc_drive_type out_one;
  hbc_pkg::hbc_drive_type out_two;
  logic                   flt_n;
  logic                   cl_act;
  logic [1:0]             cl_sel;
  logic [2:0]             slew_sel;
  logic [15:0]            rep;
  int                     failures = 0;
  int                     samples_checked = 0;
  localparam logic [1:0]  HI = 2'h2;
  localparam logic [1:0]  LO = 2'h1;
  localparam logic [1:0]  ZZ = 2'h0;

  always #20 sys_clk = ~sys_clk;

  hbc_top DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .pins(pins), .sense(sense), .power_output_one(out_one),
    .power_output_two(out_two), .fault_status_output_n(flt_n), .current_limit_active(cl_act),
    .current_limit_select(cl_sel), .slew_rate_select(slew_sel));
  hbc_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [12:0] d);
    host.xfer({1'b1, sel, d}, rep);
    cyc(10);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [12:0] e);
    host.xfer({1'b0, sel, 13'h0000}, rep);
    host.xfer({1'b0, sel, 13'h0000}, rep);
    `CHK("reply", {1'b0, sel, e}, rep)
    cyc(1);
  endtask
  task automatic outs(input logic [1:0] e1, input logic [1:0] e2, input logic efs);
    `CHK("power_output_one", e1, out_one)
    `CHK("power_output_two", e2, out_two)
    `CHK("fault_status_output_n", efs, flt_n)
  endtask
  task automatic ins(input logic i1, input logic i2);
    pins.input_pin_one = i1;
    pins.input_pin_two = i2;
    cyc(6);
  endtask
  task automatic toggle(input logic dis);
    pins.output_disable_pin = dis;
    pins.chip_enable_pin = dis;
    cyc(30);
    pins.output_disable_pin = 1'b0;
    pins.chip_enable_pin = 1'b1;
    cyc(6);
  endtask

  task automatic t_reset;
    outs(ZZ, ZZ, 1'b1);
    `CHK("current_limit_select", 2'h1, cl_sel)
    `CHK("slew_rate_select", 3'h4, slew_sel)
    rd(2'h3, 13'h0d98);
    rd(2'h2, 13'h06f1);
    rd(2'h1, 13'h0000);
    $display("test reset done");
  endtask
  task automatic t_map;
    pins.chip_enable_pin = 1'b1;
    ins(1'b1, 1'b1);
    outs(HI, LO, 1'b1);
    ins(1'b0, 1'b1);
    outs(LO, HI, 1'b1);
    ins(1'b0, 1'b0);
    outs(HI, HI, 1'b1);
    wr(2'h3, 13'h0d9f);
    outs(HI, LO, 1'b1);
    wr(2'h3, 13'h0d9b);
    outs(HI, HI, 1'b1);
    wr(2'h3, 13'h0d88);
    outs(ZZ, ZZ, 1'b1);
    wr(2'h3, 13'h0d90);
    ins(1'b1, 1'b0);
    outs(HI, LO, 1'b1);
    ins(1'b0, 1'b0);
    outs(LO, LO, 1'b1);
    wr(2'h3, 13'h0d95);
    outs(HI, LO, 1'b1);
    wr(2'h3, 13'h0d90);
    $display("test map done");
  endtask
  task automatic t_limit;
    sense.oc_detect = 1'b1;
    ins(1'b1, 1'b1);
    `CHK("current_limit_active", 1'b0, cl_act)
    wr(2'h3, 13'h0d98);
    `CHK("current_limit_active", 1'b1, cl_act)
    wr(2'h3, 13'h0998);
    `CHK("current_limit_active", 1'b0, cl_act)
    outs(HI, LO, 1'b1);
    sense.oc_detect = 1'b0;
    rd(2'h1, 13'h0004);
    wr(2'h1, 13'h0004);
    rd(2'h1, 13'h0000);
    wr(2'h3, 13'h0d98);
    $display("test limit done");
  endtask
  task automatic t_undervolt;
    sense.uv_below_fall = 1'b1;
    cyc(200);
    sense.uv_below_fall = 1'b0;
    cyc(5);
    sense.uv_below_fall = 1'b1;
    cyc(200);
    outs(HI, LO, 1'b1);
    cyc(60);
    outs(ZZ, ZZ, 1'b0);
    sense.uv_below_fall = 1'b0;
    sense.uv_above_recover = 1'b1;
    cyc(200);
    outs(ZZ, ZZ, 1'b0);
    cyc(60);
    outs(HI, LO, 1'b0);
    wr(2'h1, 13'h0200);
    outs(HI, LO, 1'b1);
    $display("test undervolt done");
  endtask
  task automatic t_overvolt;
    sense.ov_above = 1'b1;
    cyc(60);
    outs(HI, LO, 1'b1);
    cyc(30);
    outs(HI, HI, 1'b1);
    sense.ov_above = 1'b0;
    sense.ov_below_hys = 1'b1;
    cyc(6);
    outs(HI, LO, 1'b1);
    rd(2'h1, 13'h0100);
    wr(2'h1, 13'h0100);
    rd(2'h1, 13'h0000);
    $display("test overvolt done");
  endtask
  task automatic t_warn;
    sense.tw_above = 1'b1;
    cyc(6);
    outs(HI, LO, 1'b1);
    rd(2'h1, 13'h0002);
    wr(2'h1, 13'h0002);
    rd(2'h1, 13'h0002);
    sense.tw_above = 1'b0;
    sense.tw_below_hys = 1'b1;
    rd(2'h1, 13'h0000);
    $display("test warn done");
  endtask
  task automatic t_shutdown;
    sense.ot_above = 1'b1;
    cyc(290);
    outs(ZZ, ZZ, 1'b0);
    toggle(1'b0);
    outs(ZZ, ZZ, 1'b0);
    sense.ot_above = 1'b0;
    cyc(30);
    outs(ZZ, ZZ, 1'b0);
    toggle(1'b0);
    outs(HI, LO, 1'b1);
    $display("test shutdown done");
  endtask
  task automatic t_short;
    wr(2'h3, 13'h0d90);
    sense.scg_one = 1'b1;
    cyc(6);
    outs(ZZ, HI, 1'b0);
    sense.scg_one = 1'b0;
    wr(2'h1, 13'h0010);
    outs(HI, HI, 1'b1);
    wr(2'h3, 13'h0d98);
    sense.scp_two = 1'b1;
    cyc(6);
    outs(ZZ, ZZ, 1'b0);
    sense.scp_two = 1'b0;
    wr(2'h1, 13'h0080);
    outs(HI, LO, 1'b1);
    $display("test short done");
  endtask
  task automatic t_disable;
    wr(2'h0, 13'h0000);
    rd(2'h1, 13'h0800);
    pins.output_disable_pin = 1'b1;
    cyc(6);
    outs(ZZ, ZZ, 1'b0);
    toggle(1'b1);
    outs(HI, LO, 1'b1);
    rd(2'h1, 13'h0000);
    $display("test disable done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    // Reset rises just after time zero so the serial-side toggle flop sees an edge.
    #1 reset = 1'b1;
    cyc(6);
    reset = 1'b0;
    cyc(2);
    t_reset();
    t_map();
    t_limit();
    t_undervolt();
    t_overvolt();
    t_warn();
    t_shutdown();
    t_short();
    t_disable();
    report_and_stop();
  end
  initial begin
    #2000000;
    failures++;
    report_and_stop();
  end
endmodule
